// *** lcie_pkg.sv ***
package lcie_pkg;

    // bus and identifier widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int ID_W   = 10;
    localparam int LVL_W  = 3;
    localparam int NLVL   = 8;
    localparam int SGI_N  = 16;

    // special identifiers
    localparam logic [ID_W-1:0] ID_SPURIOUS    = 10'h3ff;
    localparam logic [ID_W-1:0] ID_GRP1_SPEC   = 10'h3fe;
    localparam logic [ID_W-1:0] ID_SPECIAL_MIN = 10'h3fc;

    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] OFF_CTRL      = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_TYPE      = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_ACK       = 12'h00c;
    localparam logic [ADDR_W-1:0] OFF_EOI       = 12'h010;
    localparam logic [ADDR_W-1:0] OFF_HP        = 12'h018;
    localparam logic [ADDR_W-1:0] OFF_ALIAS_ACK = 12'h020;
    localparam logic [ADDR_W-1:0] OFF_ALIAS_HP  = 12'h028;
    localparam logic [ADDR_W-1:0] OFF_STATUS    = 12'h02c;
    localparam logic [ADDR_W-1:0] OFF_VACK      = 12'h040;
    localparam logic [ADDR_W-1:0] OFF_VHP       = 12'h044;
    localparam logic [ADDR_W-1:0] OFF_VALIAS    = 12'h048;
    localparam logic [ADDR_W-1:0] OFF_VALIAS_HP = 12'h04c;
    localparam logic [ADDR_W-1:0] OFF_VCTRL     = 12'h050;
    localparam logic [ADDR_W-1:0] OFF_SYSERR    = 12'h054;
    localparam logic [ADDR_W-1:0] OFF_SET_EN    = 12'h060;
    localparam logic [ADDR_W-1:0] OFF_CLR_EN    = 12'h064;
    localparam logic [ADDR_W-1:0] OFF_APR0      = 12'h0d0;
    localparam logic [ADDR_W-1:0] OFF_APR1      = 12'h0e0;

    // control field positions
    localparam int CTL_G0_EN   = 0;
    localparam int CTL_G1NS_EN = 1;
    localparam int CTL_SPLIT   = 2;
    localparam int CTL_ACK_CONTROL  = 3;
    localparam int CTL_FIQ     = 4;
    localparam int STS_VIOL    = 4;
    localparam int SE_ABORT    = 0;
    localparam int SE_TRAP     = 1;
    localparam int SE_SUPP     = 2;
    localparam int TYPE_LOCK_LO = 11;

    typedef enum logic [1:0] {
        LCIE_GRP_NONE = 2'b00,
        LCIE_GRP_G0   = 2'b01,
        LCIE_GRP_G1NS = 2'b10
    } lcie_grp_t;

    typedef struct packed {
        logic              g0_en;
        logic              g1ns_en;
        logic              split_eoi;
        logic              fiq_sel;
        logic              vack_ctl;
        logic              abort_rt;
        logic              trap_se;
        logic              violation;
        logic [NLVL-1:0]   apr0;
        logic [NLVL-1:0]   apr1;
        logic [SGI_N-1:0]  sgi_en;
        logic [DATA_W-1:0] rdata;
        logic              ack_v;
        logic [ID_W-1:0]   ack_id;
        logic              vack_v;
        logic [ID_W-1:0]   vack_id;
        logic              drop_v;
        logic [LVL_W-1:0]  drop_lvl;
        logic              deact_v;
        logic [ID_W-1:0]   deact_id;
        logic              se_phys;
        logic              se_virt;
        logic              se_trap;
    } lcie_state_t;

    localparam lcie_state_t RST_STATE = '0;

endpackage : lcie_pkg

// *** lcie_ack_eoi.sv ***
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// RL1 - alias ack spurious when group 0 pending
// RL2 - real id acknowledge marks active, clears pending
// RL3 - eoi with nothing active: syserr, no change
// RL4 - nonsecure eoi group1: drop, deactivate unless split
// RL5 - nonsecure eoi on group 0: no drop, syserr
// RL6 - secure eoi group 0: drop, deactivate unless split
// RL7 - nonsecure group 0 eoi sets violation flag
// RL8 - nonsecure ack spurious: group0 or group1 disabled
// RL9 - secure ack spurious: not group0 or disabled
// RL10 - virtual ack spurious for invalid list register
// RL11 - virtual group1 obeys ack_control, group0 acks
// RL12 - read-only capability bit for local syserr
// RL13 - nonsecure syserr physical or virtual by routing
// RL14 - hypervisor traps local syserr when routed
// RL15 - ack_control reads zero, ignores writes
// RL16 - no lockdown input, lockable_count reads zero
// RL17 - software setting routing_modifier sets fast_irq_sel
// RL18 - sgi set-enable bits reset to zero
// RL19 - secure group1 treated as group 0
// RL20 - id 1022 only legacy, group1, signalable
// RL21 - software acks 1022 via alias registers
// RL22 - highest-pending reads select alike, no effects
module lcie_ack_eoi #(
    parameter bit SYSERR_SUPPORTED = 1'b1
) (
    // clock and reset
    input  wire logic                        clock,
    input  wire logic                        nrst,
    // register port
    input  wire logic [lcie_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [lcie_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [lcie_pkg::DATA_W-1:0] reg_rdata,
    // access context
    input  wire logic                        access_secure,
    input  wire logic                        legacy_op,
    // highest pending physical interrupt
    input  wire logic [lcie_pkg::ID_W-1:0]   hp_id,
    input  wire logic                        hp_grp0,
    input  wire logic                        hp_sec_grp1,
    input  wire logic                        hp_prio_ok,
    input  wire logic [lcie_pkg::LVL_W-1:0]  hp_lvl,
    // highest priority list_register
    input  wire logic                        lr_valid,
    input  wire logic                        lr_grp1,
    input  wire logic [lcie_pkg::ID_W-1:0]   lr_vid,
    input  wire logic                        lr_prio_ok,
    // physical interrupt state updates
    output logic                             ack_valid,
    output logic      [lcie_pkg::ID_W-1:0]   ack_id,
    output logic                             prio_drop,
    output logic      [lcie_pkg::LVL_W-1:0]  drop_lvl,
    output logic                             deact_valid,
    output logic      [lcie_pkg::ID_W-1:0]   deact_id,
    // virtual acknowledge
    output logic                             vack_valid,
    output logic      [lcie_pkg::ID_W-1:0]   vack_id,
    // local system errors
    output logic                             syserr_phys,
    output logic                             syserr_virt,
    output logic                             syserr_trap,
    // control levels
    output logic                             fast_irq_sel
);
    import lcie_pkg::*;

    lcie_state_t r;
    lcie_state_t next_r;
    logic        rst_meta;
    logic        rst_sync;
    logic        hp_g0;
    lcie_grp_t   act_grp;
    logic [LVL_W-1:0] act_lvl;

    function automatic logic is_special(input logic [ID_W-1:0] id);
        return id >= ID_SPECIAL_MIN;
    endfunction : is_special

    // physical identifier selection shared by ack and highest-pending
    function automatic logic [ID_W-1:0] phys_sel(
        input logic            secure,
        input logic            alias_rd,
        input logic            g0,
        input logic            g0_en,
        input logic            g1_en,
        input logic            legacy,
        input logic            prio_ok,
        input logic [ID_W-1:0] id
    );
        logic [ID_W-1:0] res;
        res = id;
        if (id == ID_SPURIOUS) begin
            res = ID_SPURIOUS;
        end else if (alias_rd) begin
            if (g0) res = ID_SPURIOUS;                         // see RL1
        end else if (!secure) begin
            if (g0 || !g1_en) res = ID_SPURIOUS;               // see RL8
        end else if (g0) begin
            if (!g0_en) res = ID_SPURIOUS;                     // see RL9
        end else if (legacy && prio_ok) begin
            res = ID_GRP1_SPEC;                                // see RL20
        end else begin
            res = ID_SPURIOUS;                                 // see RL9
        end
        return res;
    endfunction : phys_sel

    // virtual identifier selection shared by ack and highest-pending
    function automatic logic [ID_W-1:0] virt_sel(
        input logic            alias_rd,
        input logic            valid,
        input logic            grp1,
        input logic            ack_control,
        input logic            legacy,
        input logic            prio_ok,
        input logic [ID_W-1:0] vid
    );
        logic [ID_W-1:0] res;
        res = vid;
        if (!valid || vid == ID_SPURIOUS) begin
            res = ID_SPURIOUS;                                 // see RL10
        end else if (alias_rd) begin
            if (!grp1) res = ID_SPURIOUS;
        end else if (grp1 && !ack_control) begin
            if (legacy && prio_ok) res = ID_GRP1_SPEC;         // see RL11
            else res = ID_SPURIOUS;                            // see RL20
        end
        return res;
    endfunction : virt_sel

    // lowest set level is the highest active priority
    function automatic logic [LVL_W-1:0] low_lvl(input logic [NLVL-1:0] m);
        logic [LVL_W-1:0] k;
        k = '0;
        for (int i = NLVL - 1; i >= 0; i--) begin
            if (m[i]) k = LVL_W'(i);
        end
        return k;
    endfunction : low_lvl

    function automatic logic [DATA_W-1:0] id_word(input logic [ID_W-1:0] id);
        return {{(DATA_W-ID_W){1'b0}}, id};
    endfunction : id_word

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    assign hp_g0   = hp_grp0 || hp_sec_grp1;                   // see RL19
    assign act_lvl = low_lvl(r.apr0 | r.apr1);

    always_comb begin
        if (r.apr0[act_lvl]) act_grp = LCIE_GRP_G0;
        else if (r.apr1[act_lvl]) act_grp = LCIE_GRP_G1NS;
        else act_grp = LCIE_GRP_NONE;
    end

    always_comb begin
        logic [ID_W-1:0] id;
        logic            se_evt;
        logic            do_ret;
        id     = ID_SPURIOUS;
        se_evt = 1'b0;
        do_ret = 1'b0;
        next_r         = r;
        next_r.rdata   = '0;
        next_r.ack_v   = 1'b0;
        next_r.vack_v  = 1'b0;
        next_r.drop_v  = 1'b0;
        next_r.deact_v = 1'b0;
        next_r.se_phys = 1'b0;
        next_r.se_virt = 1'b0;
        next_r.se_trap = 1'b0;
        if (reg_rd) begin
            case (reg_addr)
                OFF_CTRL: begin
                    next_r.rdata[CTL_G0_EN]   = r.g0_en;
                    next_r.rdata[CTL_G1NS_EN] = r.g1ns_en;
                    next_r.rdata[CTL_SPLIT]   = r.split_eoi;
                    next_r.rdata[CTL_FIQ]     = r.fiq_sel;
                    next_r.rdata[CTL_ACK_CONTROL]  = 1'b0;          // see RL15
                end
                OFF_TYPE: begin
                    next_r.rdata = '0;                         // see RL16
                end
                OFF_ACK, OFF_HP, OFF_ALIAS_ACK, OFF_ALIAS_HP: begin
                    id = phys_sel(access_secure,
                                  reg_addr == OFF_ALIAS_ACK
                                  || reg_addr == OFF_ALIAS_HP,
                                  hp_g0, r.g0_en, r.g1ns_en,
                                  legacy_op, hp_prio_ok, hp_id);
                    next_r.rdata = id_word(id);
                    do_ret = reg_addr == OFF_ACK
                             || reg_addr == OFF_ALIAS_ACK;     // see RL22
                    if (do_ret && !is_special(id)) begin
                        next_r.ack_v  = 1'b1;                  // see RL2
                        next_r.ack_id = id;
                        if (hp_g0) next_r.apr0[hp_lvl] = 1'b1;
                        else next_r.apr1[hp_lvl] = 1'b1;
                    end
                end
                OFF_VACK, OFF_VHP, OFF_VALIAS, OFF_VALIAS_HP: begin
                    id = virt_sel(reg_addr == OFF_VALIAS
                                  || reg_addr == OFF_VALIAS_HP,
                                  lr_valid, lr_grp1, r.vack_ctl,
                                  legacy_op, lr_prio_ok, lr_vid);
                    next_r.rdata = id_word(id);
                    do_ret = reg_addr == OFF_VACK
                             || reg_addr == OFF_VALIAS;        // see RL22
                    if (do_ret && !is_special(id)) begin
                        next_r.vack_v  = 1'b1;                 // see RL11
                        next_r.vack_id = id;
                    end
                end
                OFF_STATUS: next_r.rdata[STS_VIOL] = r.violation;
                OFF_VCTRL: next_r.rdata[CTL_ACK_CONTROL] = r.vack_ctl;
                OFF_SYSERR: begin
                    next_r.rdata[SE_ABORT] = r.abort_rt;
                    next_r.rdata[SE_TRAP]  = r.trap_se;
                    next_r.rdata[SE_SUPP]  = SYSERR_SUPPORTED; // see RL12
                end
                OFF_SET_EN, OFF_CLR_EN: begin
                    next_r.rdata[SGI_N-1:0] = r.sgi_en;
                end
                OFF_APR0: next_r.rdata[NLVL-1:0] = r.apr0;
                OFF_APR1: next_r.rdata[NLVL-1:0] = r.apr1;
                default: next_r.rdata = '0;
            endcase
        end
        if (reg_wr) begin
            case (reg_addr)
                OFF_CTRL: begin
                    next_r.g0_en     = reg_wdata[CTL_G0_EN];
                    next_r.g1ns_en   = reg_wdata[CTL_G1NS_EN];
                    next_r.split_eoi = reg_wdata[CTL_SPLIT];
                    next_r.fiq_sel   = reg_wdata[CTL_FIQ];
                end
                OFF_EOI: begin
                    if (act_grp == LCIE_GRP_NONE) begin
                        se_evt = 1'b1;                         // see RL3
                    end else if ((act_grp == LCIE_GRP_G1NS)
                                 != access_secure) begin
                        next_r.drop_v   = 1'b1;                // see RL4
                        next_r.drop_lvl = act_lvl;             // see RL6
                        if (access_secure) begin
                            next_r.apr0[act_lvl] = 1'b0;
                        end else begin
                            next_r.apr1[act_lvl] = 1'b0;
                        end
                        if (!r.split_eoi) begin
                            next_r.deact_v  = 1'b1;
                            next_r.deact_id = reg_wdata[ID_W-1:0];
                        end
                    end else begin
                        se_evt = 1'b1;                         // see RL5
                        if (act_grp == LCIE_GRP_G0) begin
                            next_r.violation = 1'b1;           // see RL7
                        end
                    end
                end
                OFF_STATUS: begin
                    if (reg_wdata[STS_VIOL]) next_r.violation = 1'b0;
                end
                OFF_VCTRL: next_r.vack_ctl = reg_wdata[CTL_ACK_CONTROL];
                OFF_SYSERR: begin
                    next_r.abort_rt = reg_wdata[SE_ABORT];
                    next_r.trap_se  = reg_wdata[SE_TRAP];
                end
                OFF_SET_EN: next_r.sgi_en = r.sgi_en | reg_wdata[SGI_N-1:0];
                OFF_CLR_EN: begin
                    next_r.sgi_en = r.sgi_en & ~reg_wdata[SGI_N-1:0];
                end
                default: begin
                end
            endcase
        end
        if (se_evt && SYSERR_SUPPORTED) begin
            if (access_secure || !r.abort_rt) begin
                next_r.se_phys = 1'b1;                         // see RL13
            end else if (r.trap_se) begin
                next_r.se_trap = 1'b1;                         // see RL14
            end else begin
                next_r.se_virt = 1'b1;                         // see RL13
            end
        end
    end

    // reset value clears sgi enables too
    always_ff @(posedge clock or negedge rst_sync) begin
        if (!rst_sync) begin
            r <= RST_STATE;                                    // see RL18
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata    = r.rdata;
    assign ack_valid    = r.ack_v;
    assign ack_id       = r.ack_id;
    assign prio_drop    = r.drop_v;
    assign drop_lvl     = r.drop_lvl;
    assign deact_valid  = r.deact_v;
    assign deact_id     = r.deact_id;
    assign vack_valid   = r.vack_v;
    assign vack_id      = r.vack_id;
    assign syserr_phys  = r.se_phys;
    assign syserr_virt  = r.se_virt;
    assign syserr_trap  = r.se_trap;
    assign fast_irq_sel = r.fiq_sel;

    property p_alias_grp0;
        @(posedge clock) disable iff (!rst_sync)
        reg_rd && reg_addr == OFF_ALIAS_ACK && hp_g0
        |=> reg_rdata == id_word(ID_SPURIOUS) && !ack_valid;
    endproperty
    a_alias_grp0: assert property (p_alias_grp0) // see RL1
        else $error("alias ack did not hide group 0");

    property p_ack_side;
        @(posedge clock) disable iff (!rst_sync)
        reg_rd && reg_addr == OFF_ACK && !is_special(hp_id)
        && (access_secure ? hp_g0 && r.g0_en : !hp_g0 && r.g1ns_en)
        |=> ack_valid && ack_id == $past(hp_id)
            && reg_rdata == id_word($past(hp_id));
    endproperty
    a_ack_side: assert property (p_ack_side) // see RL2
        else $error("acknowledge side effect missing");

    property p_eoi_idle;
        @(posedge clock) disable iff (!rst_sync)
        reg_wr && reg_addr == OFF_EOI && r.apr0 == '0 && r.apr1 == '0
        |=> !prio_drop && !deact_valid && r.apr0 == '0 && r.apr1 == '0;
    endproperty
    a_eoi_idle: assert property (p_eoi_idle) // see RL3
        else $error("eoi with nothing active changed state");

    property p_ns_drop;
        @(posedge clock) disable iff (!rst_sync)
        reg_wr && reg_addr == OFF_EOI && !access_secure
        && act_grp == LCIE_GRP_G1NS
        |=> prio_drop && drop_lvl == $past(act_lvl)
            && deact_valid == !$past(r.split_eoi);
    endproperty
    a_ns_drop: assert property (p_ns_drop) // see RL4
        else $error("nonsecure group 1 eoi did not drop");

    property p_ns_g0;
        @(posedge clock) disable iff (!rst_sync)
        reg_wr && reg_addr == OFF_EOI && !access_secure
        && act_grp == LCIE_GRP_G0
        |=> !prio_drop && !deact_valid && r.violation;
    endproperty
    a_ns_g0: assert property (p_ns_g0) // see RL7
        else $error("nonsecure group 0 eoi mishandled");

    property p_sec_spur;
        @(posedge clock) disable iff (!rst_sync)
        reg_rd && reg_addr == OFF_ACK && access_secure && !hp_g0
        && !(legacy_op && hp_prio_ok)
        |=> reg_rdata == id_word(ID_SPURIOUS) && !ack_valid;
    endproperty
    a_sec_spur: assert property (p_sec_spur) // see RL9
        else $error("secure ack returned group 1 id");

    property p_virt_inv;
        @(posedge clock) disable iff (!rst_sync)
        reg_rd && reg_addr == OFF_VACK && !lr_valid
        |=> reg_rdata == id_word(ID_SPURIOUS) && !vack_valid;
    endproperty
    a_virt_inv: assert property (p_virt_inv) // see RL10
        else $error("invalid list register acknowledged");

    property p_route;
        @(posedge clock) disable iff (!rst_sync)
        syserr_virt || syserr_trap
        |-> $past(r.abort_rt) && !$past(access_secure)
            && syserr_trap == $past(r.trap_se) && !syserr_phys;
    endproperty
    a_route: assert property (p_route) // see RL13
        else $error("local syserr routed wrongly");

    property p_ack_control_raz;
        @(posedge clock) disable iff (!rst_sync)
        reg_rd && reg_addr == OFF_CTRL |=> !reg_rdata[CTL_ACK_CONTROL];
    endproperty
    a_ack_control_raz: assert property (p_ack_control_raz) // see RL15
        else $error("physical ack control not read as zero");

endmodule : lcie_ack_eoi

// *** lcie_far_model.sv ***
`timescale 1ns/1ps
module lcie_far_model (
    // clock and reset
    input  wire logic                       clock,
    input  wire logic                       nrst,
    // load from bench: ok, sec grp1, grp0, level, id
    input  wire logic                       ld,
    input  wire logic [15:0]                ld_word,
    // acknowledge from the interface
    input  wire logic                       ack_valid,
    input  wire logic [lcie_pkg::ID_W-1:0]  ack_id,
    // highest pending interrupt
    output logic      [lcie_pkg::ID_W-1:0]  hp_id,
    output logic                            hp_grp0,
    output logic                            hp_sec_grp1,
    output logic                            hp_prio_ok,
    output logic      [lcie_pkg::LVL_W-1:0] hp_lvl
);
    import lcie_pkg::*;
    logic [15:0] pend;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pend <= {6'h00, ID_SPURIOUS};
        end else if (ld) begin
            pend <= ld_word;
        end else if (ack_valid && ack_id == pend[9:0]) begin
            pend <= {6'h00, ID_SPURIOUS};
        end
    end
    assign hp_id       = pend[9:0];
    assign hp_lvl      = pend[12:10];
    assign hp_grp0     = pend[13];
    assign hp_sec_grp1 = pend[14];
    assign hp_prio_ok  = pend[15];
endmodule : lcie_far_model

// *** legacy_cpu_iface_ack_eoi_tb_top.sv ***
`timescale 1ns/1ps
module legacy_cpu_iface_ack_eoi_tb_top;
    import lcie_pkg::*;
    localparam logic [6:0] P_ACK = 7'h40, P_VACK = 7'h20, P_DROP = 7'h10;
    localparam logic [6:0] P_DEACT = 7'h08, P_SEP = 7'h04;
    localparam logic [6:0] P_SEV = 7'h02, P_SET = 7'h01;
    logic        clock, nrst, reg_wr, reg_rd, access_secure, legacy_op, act;
    logic        lr_valid, lr_grp1, lr_prio_ok, ld, hp_grp0, hp_sec_grp1;
    logic        hp_prio_ok, ack_valid, vack_valid, prio_drop, deact_valid;
    logic        syserr_phys, syserr_virt, syserr_trap, fast_irq_sel;
    logic [11:0] reg_addr, a;
    logic [31:0] reg_wdata, reg_rdata, r, c;
    logic [9:0]  hp_id, lr_vid, ack_id, vack_id, deact_id, e;
    logic [2:0]  hp_lvl, drop_lvl;
    logic [15:0] ld_word;
    logic [38:0] x, q [$];
    int          error_cnt, cmp_count, i, seed;
    logic [11:0] ack_addr [8] = '{OFF_ACK, OFF_HP, OFF_ALIAS_ACK,
        OFF_ALIAS_HP, OFF_VACK, OFF_VHP, OFF_VALIAS, OFF_VALIAS_HP};
    // secure, trap, abort routing, expected pulse
    logic [9:0]  se_tab [4] = '{{3'b001, P_SEV}, {3'b011, P_SET},
        {3'b010, P_SEP}, {3'b101, P_SEP}};

    lcie_ack_eoi #(.SYSERR_SUPPORTED(1'b1)) i_lcie_ack_eoi (
        .clock(clock), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .access_secure(access_secure),
        .legacy_op(legacy_op), .hp_id(hp_id), .hp_grp0(hp_grp0),
        .hp_sec_grp1(hp_sec_grp1), .hp_prio_ok(hp_prio_ok),
        .hp_lvl(hp_lvl), .lr_valid(lr_valid), .lr_grp1(lr_grp1),
        .lr_vid(lr_vid), .lr_prio_ok(lr_prio_ok), .ack_valid(ack_valid),
        .ack_id(ack_id), .prio_drop(prio_drop), .drop_lvl(drop_lvl),
        .deact_valid(deact_valid), .deact_id(deact_id),
        .vack_valid(vack_valid), .vack_id(vack_id),
        .syserr_phys(syserr_phys), .syserr_virt(syserr_virt),
        .syserr_trap(syserr_trap), .fast_irq_sel(fast_irq_sel));
    lcie_far_model i_lcie_far_model (
        .clock(clock), .nrst(nrst), .ld(ld), .ld_word(ld_word),
        .ack_valid(ack_valid), .ack_id(ack_id), .hp_id(hp_id),
        .hp_grp0(hp_grp0), .hp_sec_grp1(hp_sec_grp1),
        .hp_prio_ok(hp_prio_ok), .hp_lvl(hp_lvl));

    always #10 clock = ~clock;

    task automatic cmp(input logic [38:0] got, input logic [38:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : cmp

    task close_out;
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    task automatic acc(input logic wr, input logic [11:0] ad,
                       input logic [31:0] d, input logic [38:0] ex);
        @(posedge clock);
        reg_wr    <= wr;
        reg_rd    <= !wr;
        reg_addr  <= ad;
        reg_wdata <= d;
        q.push_back(ex);
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask : acc

    task automatic rd(input logic [11:0] ad, logic [31:0] d, logic [6:0] p);
        acc(1'b0, ad, 32'h0, {d, p});
    endtask : rd

    task automatic wr(input logic [11:0] ad, logic [31:0] d, logic [6:0] p);
        acc(1'b1, ad, d, {32'h0, p});
    endtask : wr

    task automatic load(input logic [15:0] w);
        @(posedge clock);
        ld      <= 1'b1;
        ld_word <= w;
        @(posedge clock);
        ld <= 1'b0;
    endtask : load

    function automatic logic [9:0] ref_id(input logic [11:0] ad);
        logic g0, al;
        g0 = ld_word[13] | ld_word[14];
        al = ad == OFF_ALIAS_ACK || ad == OFF_ALIAS_HP;
        if (ad >= OFF_VACK) begin
            if (!lr_valid) return ID_SPURIOUS;
            al = ad == OFF_VALIAS || ad == OFF_VALIAS_HP;
            if (!lr_grp1) return al ? ID_SPURIOUS : lr_vid;
            if (al || c[5]) return lr_vid;
            return (legacy_op && lr_prio_ok) ? ID_GRP1_SPEC : ID_SPURIOUS;
        end
        if (ld_word[9:0] == ID_SPURIOUS) return ID_SPURIOUS;
        if (al) return g0 ? ID_SPURIOUS : ld_word[9:0];
        if (!access_secure) return (g0 || !c[1]) ? ID_SPURIOUS : ld_word[9:0];
        if (g0) return c[0] ? ld_word[9:0] : ID_SPURIOUS;
        return (legacy_op && ld_word[15]) ? ID_GRP1_SPEC : ID_SPURIOUS;
    endfunction : ref_id

    function automatic logic [6:0] pulse(input logic [11:0] ad,
                                         input logic [9:0] id);
        if (id >= ID_SPECIAL_MIN) return 7'h0;
        if (ad == OFF_ACK || ad == OFF_ALIAS_ACK) return P_ACK;
        if (ad == OFF_VACK || ad == OFF_VALIAS) return P_VACK;
        return 7'h0;
    endfunction : pulse

    // results show one cycle after each strobe
    always @(posedge clock) begin
        #1;
        if (act) begin
            x = q.pop_front();
            cmp({reg_rdata, ack_valid, vack_valid, prio_drop, deact_valid,
                 syserr_phys, syserr_virt, syserr_trap}, x);
            if (ack_valid) cmp(ack_id, x[16:7]);
            if (vack_valid) cmp(vack_id, x[16:7]);
            if (deact_valid) cmp(deact_id, reg_wdata[9:0]);
        end
        act = reg_rd | reg_wr;
    end

    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        close_out();
    end

    initial begin
        seed = 32'h3c50580e;
        {clock, nrst, reg_wr, reg_rd, access_secure, legacy_op, act} = '0;
        {lr_valid, lr_grp1, lr_prio_ok, ld, lr_vid, ld_word, reg_addr} = '0;
        reg_wdata = '0;
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        repeat (4) @(posedge clock);
        rd(OFF_CTRL, 32'h0, 7'h0);
        rd(OFF_TYPE, 32'h0, 7'h0);
        rd(OFF_SET_EN, 32'h0, 7'h0);
        rd(OFF_SYSERR, 32'h4, 7'h0);
        rd(12'h0fc, 32'h0, 7'h0);
        wr(OFF_SET_EN, 32'hffff, 7'h0);
        rd(OFF_SET_EN, 32'hffff, 7'h0);
        wr(OFF_CLR_EN, 32'hffff, 7'h0);
        wr(OFF_CTRL, 32'h13, 7'h0);
        access_secure <= 1'b1;
        legacy_op <= 1'b1;
        load(16'hac25);
        rd(OFF_ACK, 32'h25, P_ACK);
        rd(OFF_APR0, 32'h8, 7'h0);
        access_secure <= 1'b0;
        wr(OFF_EOI, 32'h25, P_SEP);
        rd(OFF_STATUS, 32'h10, 7'h0);
        wr(OFF_STATUS, 32'h10, 7'h0);
        rd(OFF_STATUS, 32'h0, 7'h0);
        access_secure <= 1'b1;
        wr(OFF_EOI, 32'h25, P_DROP | P_DEACT);
        wr(OFF_EOI, 32'h25, P_SEP);
        rd(OFF_APR0, 32'h0, 7'h0);
        load(16'h9440);
        rd(OFF_ACK, 32'h3fe, 7'h0);
        rd(OFF_ALIAS_ACK, 32'h40, P_ACK);
        access_secure <= 1'b0;
        wr(OFF_CTRL, 32'h6, 7'h0);
        load(16'h9440);
        rd(OFF_ACK, 32'h40, P_ACK);
        rd(OFF_APR1, 32'h20, 7'h0);
        wr(OFF_EOI, 32'h40, P_DROP);
        rd(OFF_APR1, 32'h0, 7'h0);
        for (i = 0; i < 4; i++) begin
            access_secure <= se_tab[i][9];
            wr(OFF_SYSERR, {30'h0, se_tab[i][8:7]}, 7'h0);
            wr(OFF_EOI, 32'h0, se_tab[i][6:0]);
        end
        wr(OFF_SYSERR, 32'h0, 7'h0);
        for (i = 0; i < 200; i++) begin
            r = $random(seed);
            c = $random(seed);
            access_secure <= r[23];
            legacy_op <= r[24];
            lr_valid <= r[19];
            lr_grp1 <= r[20];
            lr_prio_ok <= r[21];
            lr_vid <= {1'b0, c[14:6]};
            wr(OFF_CTRL, {27'h0, c[4:0]}, 7'h0);
            wr(OFF_VCTRL, {28'h0, c[5], 3'h0}, 7'h0);
            rd(OFF_CTRL, {27'h0, c[4], 1'b0, c[2:0]}, 7'h0);
            cmp({38'h0, fast_irq_sel}, {38'h0, c[4]});
            load({r[15:10], (r[18:16] == 3'h0) ? ID_SPURIOUS
                                              : 10'(r[9:0] % 1020)});
            a = ack_addr[c[17:15]];
            e = ref_id(a);
            rd(a, {22'h0, e}, pulse(a, e));
        end
        close_out();
    end
endmodule : legacy_cpu_iface_ack_eoi_tb_top
